// file: hdl/srl_core.sv
// reset qualification, lockout, output latch and status logic
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "srl_defines.svh"

module srl_core
	import srl_pkg::*;
#(
	parameter int RST_MIN_CYC = `SRL_T_RST_MIN_MS * `SRL_CLK_KHZ,
	parameter int RST_MAX_CYC = `SRL_T_RST_MAX_MS * `SRL_CLK_KHZ,
	parameter int ROT_CYC = `SRL_T_ROT_MS * `SRL_CLK_KHZ,
	parameter int CARD_CYC = `SRL_T_CARD_MS * `SRL_CLK_KHZ
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic latch_reset_pin,
	input wire logic system_reset_terminal,
	input wire logic btn_up_pin,
	input wire logic btn_down_pin,
	input wire logic external_memory_card_pin,
	input wire logic manual_power_up_strap,
	input wire logic crit_fault,
	input wire logic out_fault,
	input wire logic valve_monitor_fault,
	input wire logic two_hand_fault,
	input wire logic valve_monitor_test,
	input wire logic mute_lamp_fault_in,
	input wire logic en_dev,
	input wire logic [3:0] in_run,
	input wire logic [3:0] in_fault,
	input wire logic [3:0] in_mute,
	input wire logic [3:0] in_bypass,
	input wire logic card_has_cfg,
	input wire logic card_match,
	input wire logic run_screen,
	output logic [2:0] safety_out,
	output logic [8:0] out_state,
	output logic lockout,
	output logic sys_reset_needed,
	output logic mute_lamp_fault,
	output logic [1:0] disp_out_sel,
	output logic [1:0] disp_in_sel,
	output logic disp_in_show,
	output logic [1:0] card_msg
);

	////////////////////////////////////////////////////////////////////////////
	// state and helpers

	srl_state_t q; // registered state
	srl_state_t n; // next state

	// reset image: latch needs set; cleared at once for outputs with no manual input, otherwise by a manual reset
	localparam srl_state_t ST_RST = '{ctrl: `SRL_CTRL_RST, latch_need: 3'b111, default: '0};

	// next set bit after cur, wrapping at lim; keeps cur when none set
	function automatic logic [1:0] nxt(input logic [3:0] v, input logic [1:0] cur,
		input logic [1:0] lim);
		logic [1:0] r;
		logic [2:0] c;
		r = cur;
		for (int k = 3; k >= 1; k--) begin
			c = {1'b0, cur} + 3'(k);
			if (c > {1'b0, lim}) begin
				c = c - {1'b0, lim} - 3'd1;
			end
			if (v[c[1:0]]) begin
				r = c[1:0];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped offsets answer with pslverr

	logic acc; // access phase
	logic hit; // mapped offset
	logic wr; // write takes effect this edge

	assign acc = psel & penable;
	assign pready = 1'b1;
	assign hit = (paddr == `SRL_A_CTRL) || (paddr == `SRL_A_MAP) || (paddr == `SRL_A_OPT) ||
		(paddr == `SRL_A_DLY) || (paddr == `SRL_A_ENLIM) || (paddr == `SRL_A_CMD) ||
		(paddr == `SRL_A_STAT);
	assign pslverr = acc & ~hit;
	assign wr = acc & pwrite & hit;

	// read mux; status word shows the block's live state
	always_comb begin
		prdata = 32'h0000_0000;
		if (acc && !pwrite) begin
			unique case (paddr)
				`SRL_A_CTRL: prdata = {23'h00_0000, q.ctrl};
				`SRL_A_MAP: prdata = {20'h0_0000, q.map};
				`SRL_A_OPT: prdata = {20'h0_0000, q.opt};
				`SRL_A_DLY: prdata = {6'h00, q.dly};
				`SRL_A_ENLIM: prdata = {6'h00, q.enlim};
				`SRL_A_STAT: prdata = {10'h000, q.card, q.show, q.idx, q.sel, q.mlf,
					q.sys_need, q.lockout, q.out, q.ost};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		logic [1:0] pulse; // qualified reset pulses: 0 latch, 1 system
		logic [25:0] hl; // high length including this cycle
		logic strap_set; // manual power-up strap seen
		logic newcfg; // software reports a new configuration
		logic exit_req; // software asks to leave enable mode
		logic [2:0][3:0] mp; // mapping per output
		logic [2:0][3:0] rep; // inputs worth reporting per output
		logic [2:0][3:0] abn; // muted, bypassed or faulted inputs per output
		logic [2:0] mo; // outputs that use the manual reset
		logic [2:0] offpend; // outputs in off-delay
		logic run_ok;
		logic cyc_ok;
		logic en_ok;
		logic permit;
		logic [5:0] rise;
		pulse = 2'b00;
		hl = 26'h000_0000;
		strap_set = 1'b0;
		newcfg = 1'b0;
		exit_req = 1'b0;
		mp = '0;
		rep = '0;
		abn = '0;
		mo = 3'b000;
		offpend = 3'b000;
		run_ok = 1'b0;
		cyc_ok = 1'b0;
		en_ok = 1'b0;
		permit = 1'b0;
		rise = 6'h00;
		n = q;

		// pin synchronisers; a level counts once stages two and three agree
		n.s1 = {manual_power_up_strap, external_memory_card_pin, btn_down_pin, btn_up_pin,
			system_reset_terminal, latch_reset_pin};
		n.s2 = q.s1;
		n.s3 = q.s2;
		for (int k = 0; k < 6; k++) begin
			if (q.s2[k] == q.s3[k]) begin
				n.lvl[k] = q.s3[k];
			end
		end
		rise = n.lvl & ~q.lvl;

		// register writes
		if (wr) begin
			unique case (paddr)
				`SRL_A_CTRL: n.ctrl = pwdata[8:0];
				`SRL_A_MAP: n.map = pwdata[11:0];
				`SRL_A_OPT: n.opt = pwdata[11:0];
				`SRL_A_DLY: n.dly = pwdata[25:0];
				`SRL_A_ENLIM: n.enlim = pwdata[25:0];
				`SRL_A_CMD: begin
					newcfg = pwdata[`SRL_CMD_NEWCFG];
					exit_req = pwdata[`SRL_CMD_EXIT];
					if (pwdata[`SRL_CMD_ENTER]) begin
						n.en_mode = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// pulse width counters, saturating just past the longest width
		for (int k = 0; k < 2; k++) begin
			hl = q.rcnt[k] + 26'd1;
			if (q.lvl[k]) begin
				if (q.rcnt[k] <= 26'(RST_MAX_CYC)) begin
					n.rcnt[k] = hl;
				end
			end else begin
				n.rcnt[k] = 26'h000_0000;
			end
			// trailing edge trip, width inside the window
			if (q.ctrl[k] && q.lvl[k] && !n.lvl[k] && hl >= 26'(RST_MIN_CYC) &&
				hl <= 26'(RST_MAX_CYC)) begin
				pulse[k] = 1'b1;
			end
			// trip while still held, when the high length reaches the minimum width; once per high period
			if (!q.ctrl[k] && q.lvl[k] && n.lvl[k] && hl == 26'(RST_MIN_CYC)) begin
				pulse[k] = 1'b1;
			end
		end

		// strap caught a few cycles after reset release, once the sync has settled
		if (q.pwr != `SRL_PWR_DONE) begin
			n.pwr = q.pwr + 3'd1;
		end
		strap_set = (q.pwr == `SRL_PWR_CATCH) && q.lvl[5];

		// system reset: a live critical fault keeps the lockout
		if (pulse[1] && !crit_fault) begin
			n.lockout = 1'b0;
			n.sys_need = 1'b0;
			if (q.en_mode && !en_dev) begin
				n.en_mode = 1'b0;
			end
		end
		if (crit_fault) begin
			n.lockout = 1'b1;
		end
		// sets after clears so a coincident event is never lost
		if (crit_fault || newcfg || out_fault || strap_set || exit_req ||
			valve_monitor_fault || two_hand_fault) begin
			n.sys_need = 1'b1;
		end

		// inputs that must be seen in Stop before they permit
		n.prev_run = in_run;
		for (int i = 0; i < 4; i++) begin
			if (!in_run[i]) begin
				n.stop_seen[i] = 1'b1;
			end
		end

		// enabling device active-time limit
		n.en_prev = en_dev;
		if (!en_dev) begin
			n.en_cnt = 26'h000_0000;
		end else if (q.en_mode && q.en_cnt != 26'h3FF_FFFF) begin
			n.en_cnt = q.en_cnt + 26'd1;
		end
		if (en_dev && !q.en_prev) begin
			n.timed_out = 1'b0;
		end
		if (q.en_mode && en_dev && q.en_cnt >= q.enlim) begin
			n.timed_out = 1'b1;
		end

		// mapping views per output
		for (int o = 0; o < 3; o++) begin
			for (int i = 0; i < 4; i++) begin
				mp[o][i] = q.map[3 * i + o];
			end
			mo[o] = |(mp[o] & q.opt[`SRL_OPT_MAN +: 4]);
			offpend[o] = (q.ost[o] == OS_OFFDLY);
			abn[o] = mp[o] & (in_fault | in_mute | in_bypass);
			rep[o] = abn[o] | (mp[o] & ~in_run);
		end

		// per-output latch, delay and drive
		for (int o = 0; o < 3; o++) begin
			run_ok = &(~mp[o] | in_run);
			cyc_ok = &(~(mp[o] & (q.opt[`SRL_OPT_TST +: 4] | q.opt[`SRL_OPT_THE +: 4])) |
				q.stop_seen);
			// latch release: no manual input, or a valid manual reset
			if (!mo[o]) begin
				n.latch_need[o] = 1'b0;
			end else if (pulse[0] && run_ok && !(|(offpend & mo))) begin
				n.latch_need[o] = 1'b0;
			end
			if (|(mp[o] & q.opt[`SRL_OPT_MAN +: 4] & q.prev_run & ~in_run)) begin
				n.latch_need[o] = 1'b1;
			end
			en_ok = !q.en_mode || (en_dev && !q.timed_out);
			permit = run_ok && cyc_ok && !q.latch_need[o] && !q.sys_need && !q.lockout &&
				!valve_monitor_test && en_ok;
			n.ocnt[o] = 26'h000_0000;
			if (crit_fault || q.lockout) begin
				n.out[o] = 1'b0;
			end else if (permit && !q.out[o]) begin
				if (q.ctrl[`SRL_CTRL_ONEN + o] && q.ocnt[o] < q.dly) begin
					n.ocnt[o] = q.ocnt[o] + 26'd1;
				end else begin
					n.out[o] = 1'b1;
				end
			end else if (!permit && q.out[o]) begin
				if (q.ctrl[`SRL_CTRL_OFFEN + o] && q.ocnt[o] < q.dly) begin
					n.ocnt[o] = q.ocnt[o] + 26'd1;
				end else begin
					n.out[o] = 1'b0;
				end
			end
			// operator status code, most serious first
			if (q.lockout || out_fault) begin
				n.ost[o] = OS_FAULT;
			end else if (q.en_mode) begin
				n.ost[o] = OS_ENABLE;
			end else if (q.out[o] && n.ocnt[o] != 26'h000_0000) begin
				n.ost[o] = OS_OFFDLY;
			end else if (q.out[o]) begin
				n.ost[o] = OS_ON;
			end else if (n.ocnt[o] != 26'h000_0000) begin
				n.ost[o] = OS_ONDLY;
			end else if (q.latch_need[o]) begin
				n.ost[o] = OS_RSTNEED;
			end else begin
				n.ost[o] = OS_OFF;
			end
		end

		// display rotation timer
		if (q.tick_cnt == 26'(ROT_CYC - 1)) begin
			n.tick_cnt = 26'h000_0000;
			n.sel = nxt({1'b0, ~q.out}, q.sel, 2'd2);
			if (!q.pause) begin
				n.idx = nxt(rep[q.sel], q.idx, 2'd3);
			end
		end else begin
			n.tick_cnt = q.tick_cnt + 26'd1;
		end
		if (rise[2]) begin
			n.pause = 1'b1;
		end
		if (rise[3]) begin
			n.pause = 1'b0;
			n.idx = nxt(rep[q.sel], q.idx, 2'd3);
		end
		// an output that is on hides inputs unless one is abnormal
		n.show = q.out[q.sel] ? |abn[q.sel] : |rep[q.sel];
		n.mlf = mute_lamp_fault_in;

		// memory card report, held for a short while after insertion
		if (rise[4] && run_screen) begin
			n.card = card_match ? CARD_MATCH : (card_has_cfg ? CARD_DIFF : CARD_NONE);
			n.card_cnt = 27'(CARD_CYC - 1);
		end else if (q.card_cnt != 27'h000_0000) begin
			n.card_cnt = q.card_cnt - 27'd1;
		end else begin
			n.card = CARD_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= ST_RST;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign safety_out = q.out;
	assign out_state = q.ost;
	assign lockout = q.lockout;
	assign sys_reset_needed = q.sys_need;
	assign mute_lamp_fault = q.mlf;
	assign disp_out_sel = q.sel;
	assign disp_in_sel = q.idx;
	assign disp_in_show = q.show;
	assign card_msg = q.card;

endmodule

// file: hdl/srl_defines.svh
// register offsets, field positions, reset values and timing figures
`ifndef SRL_DEFINES_SVH
`define SRL_DEFINES_SVH
// apb byte addresses
`define SRL_A_CTRL 8'h00
`define SRL_A_MAP 8'h04
`define SRL_A_OPT 8'h08
`define SRL_A_DLY 8'h0C
`define SRL_A_ENLIM 8'h10
`define SRL_A_CMD 8'h14
`define SRL_A_STAT 8'h18
// ctrl fields
`define SRL_CTRL_LMON 0
`define SRL_CTRL_SMON 1
`define SRL_CTRL_OFFEN 3
`define SRL_CTRL_ONEN 6
`define SRL_CTRL_W 9
`define SRL_CTRL_RST 9'h003
// opt fields: manual reset, start-up test, two-hand/enabling, 4 bits each
`define SRL_OPT_MAN 0
`define SRL_OPT_TST 4
`define SRL_OPT_THE 8
// cmd bits
`define SRL_CMD_NEWCFG 0
`define SRL_CMD_ENTER 1
`define SRL_CMD_EXIT 2
// timing
`define SRL_CLK_KHZ 25000
`define SRL_T_RST_MIN_MS 300
`define SRL_T_RST_MAX_MS 2000
`define SRL_T_ROT_MS 2000
`define SRL_T_CARD_MS 3000
`define SRL_PWR_CATCH 3'd4
`define SRL_PWR_DONE 3'd5
`endif

// file: hdl/srl_pkg.sv
// types shared by the reset and lockout logic
package srl_pkg;
	// per-output status shown to the operator
	typedef enum logic [2:0] {OS_OFF, OS_ON, OS_ONDLY, OS_OFFDLY, OS_RSTNEED, OS_FAULT,
		OS_ENABLE} srl_ostate_t;
	// memory card report
	typedef enum logic [1:0] {CARD_IDLE, CARD_MATCH, CARD_DIFF, CARD_NONE} srl_card_t;
	// the whole state of the block
	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] lvl;
		logic [1:0][25:0] rcnt;
		logic [2:0] pwr;
		logic [8:0] ctrl;
		logic [11:0] map;
		logic [11:0] opt;
		logic [25:0] dly;
		logic [25:0] enlim;
		logic lockout;
		logic sys_need;
		logic [2:0] latch_need;
		logic [3:0] stop_seen;
		logic [3:0] prev_run;
		logic en_mode;
		logic timed_out;
		logic en_prev;
		logic [25:0] en_cnt;
		logic [2:0] out;
		logic [2:0][25:0] ocnt;
		logic [2:0][2:0] ost;
		logic [25:0] tick_cnt;
		logic [1:0] sel;
		logic [1:0] idx;
		logic pause;
		logic show;
		logic mlf;
		logic [1:0] card;
		logic [26:0] card_cnt; // wide enough for the full card display time
	} srl_state_t;
endpackage

// file: sim/srl_core_properties.sv
// concurrent checks on the ports of the reset and lockout block
`timescale 1ns/10ps
module srl_core_chk #(
	parameter int CARD_CYC = 30
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic crit_fault,
	input wire logic out_fault,
	input wire logic valve_monitor_test,
	input wire logic mute_lamp_fault_in,
	input wire logic [2:0] safety_out,
	input wire logic lockout,
	input wire logic sys_reset_needed,
	input wire logic mute_lamp_fault,
	input wire logic [1:0] disp_out_sel,
	input wire logic [1:0] card_msg
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// cycles the card report has stood; a counter, since the real figure is huge
	logic [31:0] card_cnt_q;
	logic [31:0] card_cnt_d;
	always_comb begin
		card_cnt_d = (card_msg != 2'h0) ? card_cnt_q + 32'h0000_0001 : 32'h0000_0000;
	end
	// count register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			card_cnt_q <= 32'h0000_0000;
		end else begin
			card_cnt_q <= card_cnt_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_crit_off: assert property (crit_fault |=> safety_out == 3'h0)
		else $error("outputs not forced off after critical fault");
	a_crit_lock: assert property (crit_fault |=> lockout)
		else $error("critical fault did not hold lockout");
	a_lock_off: assert property (lockout |=> safety_out == 3'h0)
		else $error("output on during lockout");
	a_rise_permit: assert property ($rose(safety_out[1]) |->
		!$past(sys_reset_needed) && !$past(lockout) && !$past(valve_monitor_test))
		else $error("output rose without permission");
	a_need_set: assert property (out_fault |=> sys_reset_needed)
		else $error("output fault did not demand system reset");
	a_mlf_follow: assert property ($past(rst_n) |->
		mute_lamp_fault == $past(mute_lamp_fault_in))
		else $error("mute lamp status does not follow its input");
	a_card_brief: assert property (card_cnt_q <= CARD_CYC + 1)
		else $error("card report stood too long");
	a_sel_range: assert property (disp_out_sel != 2'h3)
		else $error("output selection out of range");
endmodule

bind srl_core srl_core_chk #(.CARD_CYC(CARD_CYC)) u_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.crit_fault(crit_fault),
	.out_fault(out_fault),
	.valve_monitor_test(valve_monitor_test),
	.mute_lamp_fault_in(mute_lamp_fault_in),
	.safety_out(safety_out),
	.lockout(lockout),
	.sys_reset_needed(sys_reset_needed),
	.mute_lamp_fault(mute_lamp_fault),
	.disp_out_sel(disp_out_sel),
	.card_msg(card_msg)
);

// file: sim/srl_button_model.sv
// push-button model: holds a reset pin high for a chosen number of cycles
`timescale 1ns/10ps
module srl_button_model (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [7:0] width,
	output logic pin,
	output logic busy
);
	logic [7:0] cnt_q = 8'h00;
	logic pin_q = 1'h0; // contact state, one driver only
	// contact closes on go and opens after width cycles; pulled low when open
	always @(posedge clk_sys) begin
		if (go && !busy) begin
			pin_q <= 1'h1;
			cnt_q <= width;
		end else if (cnt_q > 8'h01) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			pin_q <= 1'h0;
			cnt_q <= 8'h00;
		end
	end
	assign pin = pin_q;
	assign busy = pin_q;
endmodule

// file: sim/srl_core_tb.sv
// self-checking testbench for the reset and lockout block
`timescale 1ns/10ps
`include "srl_defines.svh"
module srl_core_tb;
	import srl_pkg::*;
	logic clk_sys = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00, w_l = 8'h00, w_s = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, crit = 1'h0, vm_test = 1'h0, mlf_in = 1'h0;
	logic [2:0] flt = 3'h0, so;
	logic [3:0] in_run = 4'hf, in_fault = 4'h0, in_mute = 4'h0;
	logic card_pin = 1'h0, card_cfg = 1'h0, card_eq = 1'h0, go_l = 1'h0, go_s = 1'h0;
	logic pin_l, pin_s, busy_l, busy_s, lk, srn, mlf, show;
	logic up = 1'h0, dn = 1'h0, en = 1'h0;
	logic [3:0] byp = 4'h0;
	logic [1:0] osel, isel;
	logic [8:0] ost;
	logic [1:0] card;
	int num_errors = 0, num_checks = 0, cyc = 0;
	// 25 MHz system clock
	initial forever #20 clk_sys = ~clk_sys;
	srl_button_model u_latch (.clk_sys(clk_sys), .go(go_l), .width(w_l), .pin(pin_l),
		.busy(busy_l));
	srl_button_model u_sys (.clk_sys(clk_sys), .go(go_s), .width(w_s), .pin(pin_s),
		.busy(busy_s));
	// short counts keep the run brief; expectations follow these values
	srl_core #(.RST_MIN_CYC(20), .RST_MAX_CYC(100), .ROT_CYC(16), .CARD_CYC(30)) DUT (
		.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .latch_reset_pin(pin_l),
		.system_reset_terminal(pin_s), .btn_up_pin(up), .btn_down_pin(dn),
		.external_memory_card_pin(card_pin), .manual_power_up_strap(1'h0),
		.crit_fault(crit), .out_fault(flt[0]), .valve_monitor_fault(flt[1]),
		.two_hand_fault(flt[2]), .valve_monitor_test(vm_test),
		.mute_lamp_fault_in(mlf_in), .en_dev(en), .in_run(in_run),
		.in_fault(in_fault), .in_mute(in_mute), .in_bypass(byp),
		.card_has_cfg(card_cfg), .card_match(card_eq), .run_screen(1'h1),
		.safety_out(so), .out_state(ost), .lockout(lk), .sys_reset_needed(srn),
		.mute_lamp_fault(mlf), .disp_out_sel(osel), .disp_in_sel(isel), .disp_in_show(show),
		.card_msg(card));
	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one apb transfer: setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// press a reset button (s=1 system) and wait until it is released and seen
	task automatic press(input logic s, input logic [7:0] w);
		@(posedge clk_sys);
		if (s) begin
			go_s <= 1'h1;
			w_s <= w;
		end else begin
			go_l <= 1'h1;
			w_l <= w;
		end
		@(posedge clk_sys);
		go_s <= 1'h0;
		go_l <= 1'h0;
		// the contact closes at this edge, so look from the next one on
		do @(posedge clk_sys); while (busy_s || busy_l);
		tick(8);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// monitored system reset: short and long pulses refused, proper one accepted
	task automatic t_sysreset();
		apb(1'h1, `SRL_A_CMD, 32'h0000_0001);
		tick(3);
		chk(srn, 1);
		chk(so, 0);
		press(1'h1, 8'd10);
		chk(srn, 1);
		press(1'h1, 8'd120);
		chk(srn, 1);
		press(1'h1, 8'd40);
		chk(srn, 0);
		chk(so, 3'h3);
		chk(ost[2:0], OS_ON);
		$display("system reset test done");
	endtask
	// manual reset needs Run inputs; Run-Stop-Run latches the output off
	task automatic t_latch();
		in_run[0] <= 1'h0;
		tick(6);
		press(1'h0, 8'd40);
		chk(so[0], 0);
		in_run[0] <= 1'h1;
		tick(6);
		press(1'h0, 8'd40);
		chk(so[0], 1);
		in_run[0] <= 1'h0;
		tick(6);
		chk(so[0], 0);
		in_run[0] <= 1'h1;
		tick(6);
		chk(so[0], 0);
		chk(ost[2:0], OS_RSTNEED);
		$display("manual reset test done");
	endtask
	// non-monitored latch reset acts while the button is still held
	task automatic t_nonmon();
		apb(1'h1, `SRL_A_CTRL, 32'h0000_0000);
		@(posedge clk_sys);
		go_l <= 1'h1;
		w_l <= 8'd200;
		@(posedge clk_sys);
		go_l <= 1'h0;
		tick(40);
		chk(so[0], 1);
		while (busy_l) @(posedge clk_sys);
		tick(8);
		chk(so[0], 1);
		$display("non-monitored test done");
	endtask
	// start-up test, stop forcing off, status line while all outputs on
	task automatic t_startup();
		in_run[2] <= 1'h0;
		tick(6);
		in_run[2] <= 1'h1;
		tick(6);
		chk(so[2], 1);
		in_run[1] <= 1'h0;
		tick(6);
		chk(so[1], 0);
		in_run[1] <= 1'h1;
		tick(6);
		chk(so, 3'h7);
		chk(show, 0);
		in_mute <= 4'h1 << osel;
		tick(40);
		chk(show, 1);
		chk(isel, osel);
		in_mute <= 4'h0;
		$display("start-up test done");
	endtask
	// lockout persists while the fault stays; fault events demand a system reset
	task automatic t_lockout();
		crit <= 1'h1;
		tick(3);
		chk({lk, so}, 4'h8);
		press(1'h1, 8'd40);
		chk({lk, so}, 4'h8);
		crit <= 1'h0;
		press(1'h1, 8'd40);
		chk({lk, so}, 4'h7);
		for (int i = 0; i < 3; i++) begin
			flt[i] <= 1'h1;
			tick(1);
			flt[i] <= 1'h0;
			tick(3);
			chk({srn, so}, 4'h8);
			press(1'h1, 8'd40);
			chk({srn, so}, 4'h7);
		end
		$display("lockout test done");
	endtask
	// valve test holds outputs off then releases them; mute lamp status
	task automatic t_valve();
		vm_test <= 1'h1;
		mlf_in <= 1'h1;
		tick(3);
		chk({mlf, so}, 4'h8);
		vm_test <= 1'h0;
		mlf_in <= 1'h0;
		tick(6);
		chk({mlf, so}, 4'h7);
		$display("valve test done");
	endtask
	// card insertion reports match, differ and empty, then clears
	task automatic t_card();
		for (int i = 0; i < 3; i++) begin
			card_cfg <= (i != 2);
			card_eq <= (i == 0);
			tick(1);
			card_pin <= 1'h1;
			tick(8);
			chk(card, i + 1);
			card_pin <= 1'h0;
			tick(40);
			chk(card, 0);
		end
		$display("card test done");
	endtask
	// enable mode: outputs follow the enabling device, time out, leave on system reset
	task automatic t_enable();
		apb(1'h1, `SRL_A_ENLIM, 32'h0000_000a);
		apb(1'h1, `SRL_A_CMD, 32'h0000_0002);
		tick(3);
		chk(so, 0);
		chk(ost[2:0], OS_ENABLE);
		en <= 1'h1;
		tick(4);
		chk(so, 3'h7);
		tick(20);
		chk(so, 0);
		en <= 1'h0;
		tick(2);
		en <= 1'h1;
		tick(4);
		chk(so, 3'h7);
		en <= 1'h0;
		press(1'h1, 8'd40);
		chk(so, 3'h7);
		chk(ost[2:0], OS_ON);
		$display("enable test done");
	endtask
	// two reported inputs on the selected output; up pauses, down advances
	task automatic t_disp();
		logic [1:0] i0;
		apb(1'h1, `SRL_A_MAP, 32'h0000_0111 | (32'h0000_0001 << (9 + osel)));
		in_mute <= 4'h1 << osel;
		byp <= 4'h8;
		tick(40);
		chk(show, 1);
		up <= 1'h1;
		tick(6);
		up <= 1'h0;
		tick(6);
		i0 = isel;
		tick(40);
		chk(isel, i0);
		dn <= 1'h1;
		tick(5);
		chk(isel, (i0 == 2'd3) ? {30'h0000_0000, osel} : 32'h0000_0003);
		dn <= 1'h0;
		in_mute <= 4'h0;
		byp <= 4'h0;
		tick(6);
		$display("display test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		tick(4);
		rst_n <= 1'h1;
		apb(1'h0, `SRL_A_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		apb(1'h0, 8'h40, 32'h0000_0000);
		chk({31'h0000_0000, err}, 1);
		chk(rd, 0);
		apb(1'h1, `SRL_A_MAP, 32'h0000_0111);
		apb(1'h1, `SRL_A_OPT, 32'h0000_0041);
		t_sysreset();
		t_latch();
		t_nonmon();
		t_startup();
		t_lockout();
		t_valve();
		t_card();
		t_enable();
		t_disp();
		stop_test();
	end
endmodule
